// File: iga_host_model.sv
// host processor model driving the register port
`timescale 1ns/1ps
module iga_host_model
    import iga_pkg::*;
(
    input wire logic mclk,
    output logic [ADDR_W-1:0] regAddr,
    output logic [31:0] regWdata,
    output logic regWr,
    output logic regRd
);
    // idle bus at time zero
    initial begin
        regAddr = '0;
        regWdata = '0;
        regWr = 1'b0;
        regRd = 1'b0;
    end
    // one-cycle write
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        regWdata <= ~d;
    endtask : wr
    // one-cycle read
    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
    endtask : rd
endmodule : iga_host_model

// File: iga_input_gain_ctrl.sv
// shared stereo input gain stage control: level control, zero cross, fades
//
// What this block does
// - limit from smaller gain, abandoning pending recovery
// - idle between recoveries: limit from held gain
// - gain writes ignored while level control on
// - recovery halts above reset level, resumes below
// - recovery stops at reference gain
// - short wait paced by limiter timeout
// - zero cross detected per channel when off
// - host write in manual mode restarts shared timeout counter
// - written gain applies at crossing or timeout
// - pending wait is not restarted by writes
// - fade-in rise: step up per period, zero cross
// - fade-in ends at reference or on limiting
// - fade-out wins over fade-in
// - fade time is 96 periods over step count
// - fade-out steps to mute and holds
// - limiting in fade-out keeps total duration
// - fade-out cleared: resume level control from current
// - both cleared: stop and freeze gain
// - fade uses fade period as timeout
// - either channel over threshold: attenuate both
// - recovery after wait while 2dB below threshold
`timescale 1ns/1ps
module iga_input_gain_ctrl
    import iga_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic fsTick,
    input wire iga_level_t level,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic [GAIN_W-1:0] gainLeft,
    output logic [GAIN_W-1:0] gainRight
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    iga_ctrl_t ctrl_r;              // control word
    logic [6:0] hostGain_r;         // host gain value
    logic [6:0] refGain_r;          // reference gain level
    iga_state_t state_r;            // current mode
    iga_state_t state_nxt;          // next mode
    logic [6:0] target_r;           // gain waiting to be applied
    logic [6:0] gain_r [2];         // applied gain per channel
    logic pend_r [2];               // channel waiting for update
    logic recov_r;                  // pending step is a recovery
    logic [10:0] zcCnt_r;           // shared zero cross timeout counter
    logic [10:0] waitCnt_r;         // recovery wait counter
    logic [10:0] fadeCnt_r;         // fade period counter
    logic [6:0] fadeLeft_r;         // fade-out steps still to run
    logic fadeInPrev_r, fadeOutPrev_r; // fade bits, last cycle
    logic [31:0] rdata_r;           // read data
    logic [6:0] curMin;             // smaller channel gain
    logic [6:0] fadeBase;           // fades build on a pending target
    logic [2:0] limStep, recStep, fadeStep; // step sizes
    logic [10:0] zcLimit, waitLimit, fadeLimit; // timeout, wait, fade period
    logic pendAny, overAny, nearAny; // any channel pending, over, near
    logic zcDone, fadeTick, waitDone; // timeout, fade period, wait ends
    logic noZc;                     // limiter ignores zero cross
    logic fading;                   // in a fade mode
    logic limitOk;                  // limiter may step now
    logic fadeInRise, fadeOutRise;  // fade bits went 0 to 1
    logic wrCtrl, wrGain, wrRef;    // register writes
    logic manGainWr;                // gain write accepted
    logic step, stepRec;            // automatic step, a recovery
    logic [6:0] stepVal;            // new target of step
    logic freeze;                   // drop pending updates
    logic [6:0] limVal, recVal, finVal, foutVal; // step targets
    logic apply [2];                // channel takes target
    ////////////////////////////////////////////////////////////////////////
    // helpers
    // add with ceiling
    function automatic logic [6:0] addClamp(input logic [6:0] a,
                                            input logic [2:0] b,
                                            input logic [6:0] lim);
        logic [7:0] s;
        s = {1'b0, a} + {5'h00, b};
        if (s > {1'b0, lim}) begin
            return lim;
        end
        return s[6:0];
    endfunction : addClamp

    // subtract with floor at mute
    function automatic logic [6:0] subFloor(input logic [6:0] a,
                                            input logic [2:0] b);
        if (a > {4'h0, b}) begin
            return a - {4'h0, b};
        end
        return GAIN_MUTE;
    endfunction : subFloor

    ////////////////////////////////////////////////////////////////////////
    // register decode

    assign wrCtrl = regWr && (regAddr == OFS_CTRL);
    assign wrGain = regWr && (regAddr == OFS_GAIN);
    assign wrRef = regWr && (regAddr == OFS_REF);
    // gain writes dropped while level control owns the gain
    assign manGainWr = wrGain && !ctrl_r.inputLevelControlEnable;

    // control word
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_r <= regWdata[CTRL_W-1:0];
        end
    end

    // host gain and reference level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hostGain_r <= GAIN_RST;
            refGain_r <= REF_RST;
        end else begin
            if (manGainWr) begin
                hostGain_r <= regWdata[6:0];
            end
            if (wrRef) begin
                refGain_r <= regWdata[6:0];
            end
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= 32'h00000000; // zero outside the read slot
            if (regRd) begin
            unique case (regAddr)
                OFS_CTRL: rdata_r[CTRL_W-1:0] <= ctrl_r;
                OFS_GAIN: rdata_r[6:0] <= hostGain_r;
                OFS_REF: rdata_r[6:0] <= refGain_r;
                OFS_STAT: begin
                    rdata_r[STAT_GAINL_LSB +: 7] <= gain_r[0];
                    rdata_r[STAT_GAINR_LSB +: 7] <= gain_r[1];
                    rdata_r[STAT_PEND_LSB] <= pend_r[0];
                    rdata_r[STAT_PEND_LSB+1] <= pend_r[1];
                    rdata_r[STAT_STATE_LSB +: 4] <= state_r;
                end
                default: rdata_r <= 32'h00000000; // unmapped reads zero
            endcase
            end
        end
    end
    assign regRdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // derived values

    assign curMin = (gain_r[0] < gain_r[1]) ? gain_r[0] : gain_r[1];
    assign pendAny = pend_r[0] || pend_r[1];
    assign overAny = |level.overLimit;
    assign nearAny = |level.nearLimit;
    assign limStep = {1'b0, ctrl_r.limiterAttenStep} + 3'h1;
    assign recStep = ctrl_r.recoveryAttenSelect ? 3'h2 : 3'h1;
    assign fadeStep = {1'b0, ctrl_r.fadeStepCount} + 3'h1;
    assign fading = (state_r == ST_FIN) || (state_r == ST_FOUT);
    assign waitLimit = WAIT_TBL[ctrl_r.recoveryWaitSelect];
    assign fadeLimit = FADE_PER_TBL[ctrl_r.fadePeriodSelect];
    // limiter step without zero cross
    assign noZc = ctrl_r.limiterZeroCrossDisable && (state_r == ST_ALC) && !recov_r;

    // choose timeout: fade period during fades
    always_comb begin
        if (fading) begin
            zcLimit = fadeLimit;
        end else if (noZc) begin
            zcLimit = LIM_TMO_TBL[ctrl_r.limiterTimeoutSelect];
        end else begin
            zcLimit = ZC_TMO_TBL[ctrl_r.zeroCrossTimeoutSelect];
        end
    end

    assign zcDone = pendAny && fsTick && (zcCnt_r >= zcLimit - 11'h001);
    assign fadeTick = fading && fsTick && (fadeCnt_r >= fadeLimit - 11'h001);
    assign waitDone = waitCnt_r >= waitLimit - 11'h001;
    // limiter may cut into a pending recovery, not a pending cut
    assign limitOk = overAny && (!pendAny || recov_r);
    assign fadeInRise = ctrl_r.fadeInEnable && !fadeInPrev_r;
    assign fadeOutRise = ctrl_r.fadeOutEnable && !fadeOutPrev_r;
    // step targets; a fade step due as the last one lands must not be lost
    assign fadeBase = pendAny ? target_r : curMin;
    assign limVal = subFloor(curMin, limStep);
    assign recVal = addClamp(curMin, recStep, refGain_r);
    assign finVal = addClamp(fadeBase, fadeStep, refGain_r);
    assign foutVal = (fadeLeft_r <= {4'h0, fadeStep}) ? GAIN_MUTE
                   : subFloor((fadeBase < curMin) ? fadeBase : curMin, fadeStep);

    ////////////////////////////////////////////////////////////////////////
    // mode decisions

    always_comb begin
        state_nxt = state_r;
        step = 1'b0;
        stepRec = 1'b0;
        stepVal = target_r;
        freeze = 1'b0;
        unique case (state_r)
            // host drives the gain
            ST_MAN: begin
                if (ctrl_r.inputLevelControlEnable) begin
                    if (ctrl_r.fadeOutEnable) begin
                        state_nxt = ST_FOUT;
                    end else if (fadeInRise) begin
                        state_nxt = ST_FIN;
                    end else begin
                        state_nxt = ST_ALC;
                    end
                end
            end
            // limiter and recovery
            ST_ALC: begin
                if (!ctrl_r.inputLevelControlEnable) begin
                    state_nxt = ST_MAN;
                    freeze = 1'b1;
                end else if (fadeOutRise) begin
                    state_nxt = ST_FOUT;
                end else if (fadeInRise && !ctrl_r.fadeOutEnable) begin
                    state_nxt = ST_FIN;
                end else if (limitOk) begin
                    step = 1'b1;
                    stepVal = limVal;
                end else if (waitDone && !pendAny && !nearAny
                             && (curMin < refGain_r)) begin
                    step = 1'b1;
                    stepRec = 1'b1;
                    stepVal = recVal;
                end
            end
            // ramp up toward the reference
            ST_FIN: begin
                if (!ctrl_r.inputLevelControlEnable) begin
                    state_nxt = ST_MAN;
                    freeze = 1'b1;
                end else if (ctrl_r.fadeOutEnable) begin
                    state_nxt = ST_FOUT;
                end else if (limitOk) begin
                    step = 1'b1;
                    stepVal = limVal;
                    state_nxt = ST_ALC;
                end else if (curMin >= refGain_r) begin
                    state_nxt = ST_ALC;
                end else if (fadeTick && (!pendAny || zcDone)) begin
                    step = 1'b1;
                    stepRec = 1'b1;
                    stepVal = finVal;
                end
            end
            // ramp down to mute and hold
            ST_FOUT: begin
                if (!ctrl_r.fadeOutEnable && !ctrl_r.inputLevelControlEnable) begin
                    state_nxt = ST_MAN;
                    freeze = 1'b1;
                end else if (!ctrl_r.fadeOutEnable) begin
                    state_nxt = ST_ALC;
                end else if (limitOk) begin
                    step = 1'b1;
                    stepVal = limVal;
                end else if (fadeTick && curMin != GAIN_MUTE) begin
                    step = 1'b1;
                    stepRec = 1'b1;
                    stepVal = foutVal;
                end
            end
            default: begin
                state_nxt = ST_MAN; // illegal code
                freeze = 1'b1;
            end
        endcase
    end

    // mode register and enable history
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= ST_MAN;
            fadeInPrev_r <= 1'b0;
            fadeOutPrev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            fadeInPrev_r <= ctrl_r.fadeInEnable;
            fadeOutPrev_r <= ctrl_r.fadeOutEnable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fade timing

    // fade period counter, restarts on entering a fade
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fadeCnt_r <= 11'h000;
        end else if (!fading || state_nxt != state_r || fadeTick) begin
            fadeCnt_r <= 11'h000;
        end else if (fsTick) begin
            fadeCnt_r <= fadeCnt_r + 11'h001;
        end
    end

    // fade-out budget, counted per period so limiting does not stretch it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fadeLeft_r <= FADE_SPAN;
        end else if (state_r != ST_FOUT) begin
            fadeLeft_r <= FADE_SPAN;
        end else if (fadeTick) begin
            fadeLeft_r <= subFloor(fadeLeft_r, fadeStep);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // recovery wait

    // restarts on each step and while input is near the threshold
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            waitCnt_r <= 11'h000;
        end else if (nearAny || overAny || step) begin
            waitCnt_r <= 11'h000;
        end else if (fsTick && !waitDone) begin
            waitCnt_r <= waitCnt_r + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // target and shared timeout

    // target gain and step kind
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            target_r <= GAIN_RST;
            recov_r <= 1'b0;
        end else if (freeze) begin
            target_r <= curMin;
            recov_r <= 1'b0;
        end else if (step) begin
            target_r <= stepVal;
            recov_r <= stepRec;
        end else if (state_r == ST_MAN && manGainWr) begin
            target_r <= regWdata[6:0];
            recov_r <= 1'b0;
        end
    end

    // shared counter: a write restarts it only when nothing waits
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            zcCnt_r <= 11'h000;
        end else if (step || zcDone) begin
            zcCnt_r <= 11'h000;
        end else if (state_r == ST_MAN && regWr && !pendAny) begin
            zcCnt_r <= 11'h000;
        end else if (pendAny && fsTick) begin
            zcCnt_r <= zcCnt_r + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per channel update

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : gChan
            // crossing on own channel, or the shared timeout
            assign apply[ch] = pend_r[ch]
                && ((level.zeroCross[ch] && !noZc) || zcDone);
            // applied gain and pending flag
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    gain_r[ch] <= GAIN_RST;
                    pend_r[ch] <= 1'b0;
                end else if (freeze) begin
                    pend_r[ch] <= 1'b0;
                end else if (step) begin
                    pend_r[ch] <= 1'b1;
                    if (apply[ch]) begin
                        gain_r[ch] <= target_r;
                    end
                end else if (state_r == ST_MAN && manGainWr && !pendAny) begin
                    pend_r[ch] <= 1'b1;
                end else if (apply[ch]) begin
                    gain_r[ch] <= target_r;
                    pend_r[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    assign gainLeft = gain_r[0];
    assign gainRight = gain_r[1];

endmodule : iga_input_gain_ctrl

// File: iga_input_gain_ctrl_assertions.sv
// port-level checks for the input gain controller
`timescale 1ns/1ps
module iga_input_gain_ctrl_assertions
    import iga_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic fsTick,
    input wire iga_level_t level,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic [GAIN_W-1:0] gainLeft,
    input wire logic [GAIN_W-1:0] gainRight
);
    logic [16:0] ctrl_r; // control word as last written
    logic [6:0] gain_r; // gain word as last accepted
    logic [6:0] ref_r; // reference gain as last written
    logic gainWr_r; // gain written in manual mode
    logic rdUnmap, rdStat; // unmapped and status reads
    assign rdUnmap = regRd && !(regAddr inside {OFS_CTRL, OFS_GAIN, OFS_REF, OFS_STAT});
    assign rdStat = regRd && (regAddr == OFS_STAT);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    // shadow copies follow the host writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            ref_r <= REF_RST;
        end else if (regWr && regAddr == OFS_CTRL) begin
            ctrl_r <= regWdata[16:0];
        end else if (regWr && regAddr == OFS_REF) begin
            ref_r <= regWdata[6:0];
        end
    end
    // gain writes only count in manual mode
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gain_r <= GAIN_RST;
            gainWr_r <= 1'b0;
        end else if (regWr && regAddr == OFS_GAIN && !ctrl_r[0]) begin
            gain_r <= regWdata[6:0];
            gainWr_r <= 1'b1;
        end else if (regWr && regAddr == OFS_CTRL && ctrl_r[0]) begin
            gainWr_r <= 1'b0;
        end
    end
    ////////////////////////////////////////
    property p_rdata_idle;
        regRdata != 32'h00000000 |-> $past(regRd);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    property p_rd_unmap;
        $past(rdUnmap) |-> regRdata == 32'h00000000;
    endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
    property p_stat_gain;
        $past(rdStat) |-> regRdata[6:0] == $past(gainLeft) && regRdata[14:8] == $past(gainRight);
    endproperty
    a_stat_gain: assert property (p_stat_gain) else $error("status gains differ");
    property p_stat_state;
        $past(rdStat) |-> $onehot(regRdata[23:20]);
    endproperty
    a_stat_state: assert property (p_stat_state) else $error("mode not one-hot");
    property p_ctrl_rb;
        $past(regRd) && $past(regAddr) == OFS_CTRL |-> regRdata[16:0] == $past(ctrl_r);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
    property p_gain_rb;
        $past(regRd) && $past(regAddr) == OFS_GAIN |-> regRdata[6:0] == $past(gain_r);
    endproperty
    a_gain_rb: assert property (p_gain_rb) else $error("gain write not dropped");
    property p_manual_hold;
        !ctrl_r[0] && !$past(ctrl_r[0]) && !gainWr_r |-> $stable(gainLeft) && $stable(gainRight);
    endproperty
    a_manual_hold: assert property (p_manual_hold) else $error("gain moved unasked");
    property p_gain_ref;
        ctrl_r[2:0] == 3'b001 && $past(ctrl_r[2:0]) == 3'b001 && gainLeft > $past(gainLeft)
            |-> gainLeft <= ref_r;
    endproperty
    a_gain_ref: assert property (p_gain_ref) else $error("recovery above reference");
    property p_fout_down;
        ctrl_r[0] && ctrl_r[2] && $past(ctrl_r[0]) && $past(ctrl_r[2])
            |-> gainLeft <= $past(gainLeft) && gainRight <= $past(gainRight);
    endproperty
    a_fout_down: assert property (p_fout_down) else $error("gain rose in fade-out");
endmodule : iga_input_gain_ctrl_assertions
bind iga_input_gain_ctrl iga_input_gain_ctrl_assertions i_iga_input_gain_ctrl_assertions (
    .mclk(mclk), .rst(rst), .fsTick(fsTick), .level(level), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .gainLeft(gainLeft), .gainRight(gainRight));

// File: iga_input_gain_ctrl_test.sv
// self-checking testbench for the input gain controller
`timescale 1ns/1ps
module iga_input_gain_ctrl_test;
    import iga_pkg::*;
    typedef struct packed {logic [3:0] a; logic [31:0] m; logic [31:0] v;} iga_chk_t;
    localparam logic [31:0] SM = 32'h00f37f7f; // mode, pending, gains
    localparam logic [31:0] GM = 32'h00f07f7f; // mode and gains
    logic mclk, rst, fsTick, regWr, regRd, rdLate;
    iga_level_t level;
    logic [ADDR_W-1:0] regAddr;
    logic [31:0] regWdata, regRdata, rnd;
    logic [GAIN_W-1:0] gainLeft, gainRight, gA, gB, gM;
    iga_chk_t expQ[$]; // reads awaiting their answer
    iga_chk_t c;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    iga_input_gain_ctrl i_iga_input_gain_ctrl (.mclk(mclk), .rst(rst), .fsTick(fsTick),
        .level(level), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .gainLeft(gainLeft), .gainRight(gainRight));
    iga_host_model i_iga_host_model (.mclk(mclk), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd));
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // status word from mode and gains
    function automatic logic [31:0] st(input logic [3:0] s, input logic [6:0] l,
        input logic [6:0] r);
        return {8'h00, s, 4'h0, 1'b0, r, 1'b0, l};
    endfunction : st
    // note, then read
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
        expQ.push_back('{a, m, v});
        i_iga_host_model.rd(a);
    endtask : rd
    // zero cross pulse
    task automatic zc(input logic [1:0] m);
        @(posedge mclk);
        level.zeroCross <= m;
        @(posedge mclk);
        level.zeroCross <= 2'b00;
    endtask : zc
    task final_report;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // sample tick every other cycle, timeout ceiling
    always @(posedge mclk) begin
        fsTick <= rst ? 1'b0 : ~fsTick;
        rdLate <= regRd;
        cycles++;
        if (cycles == 40000) begin
            n_errors++;
            $display("[ERR] run length expected end seen hang");
            final_report();
        end
    end
    // read answer check
    always @(negedge mclk) begin
        if (rdLate) begin
            c = expQ.pop_front();
            cmp_count++;
            if ((regRdata & c.m) !== (c.v & c.m)) begin
                n_errors++;
                $display("[ERR] reg %h expected %h seen %h", c.a, c.v & c.m, regRdata & c.m);
            end
        end
    end
    ////////////////////////////////////////
    initial begin
        rst = 1'b1;
        level = '0;
        rnd = xs(32'h00015668);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_CTRL, 32'h0001ffff, 32'h00000000);
        rd(OFS_GAIN, 32'h0000007f, 32'h00000000);
        rd(OFS_REF, 32'h0000007f, {25'h0, REF_RST});
        rd(4'h2, 32'hffffffff, 32'h00000000);
        rd(OFS_STAT, SM, st(4'h1, GAIN_RST, GAIN_RST));
        $display("test reset done");
        gA = (rnd[6:0] & 7'h3f) | 7'h10;
        gB = gA ^ 7'h0f;
        gM = (gA < gB) ? gA : gB;
        i_iga_host_model.wr(OFS_GAIN, {25'h0, gA});
        zc(2'b01);
        rd(OFS_STAT, SM, st(4'h1, gA, GAIN_MUTE) | 32'h00020000);
        i_iga_host_model.wr(OFS_GAIN, {25'h0, gB});
        repeat (300) @(posedge mclk);
        rd(OFS_STAT, SM, st(4'h1, gA, gB));
        $display("test manual done");
        i_iga_host_model.wr(OFS_REF, {25'h0, gM});
        i_iga_host_model.wr(OFS_CTRL, 32'h00000001);
        i_iga_host_model.wr(OFS_GAIN, 32'h00000011);
        rd(OFS_GAIN, 32'h0000007f, {25'h0, gB});
        @(posedge mclk);
        level.nearLimit <= 2'b11;
        level.overLimit <= 2'b10;
        @(posedge mclk);
        level.overLimit <= 2'b00;
        zc(2'b11);
        rd(OFS_STAT, GM, st(4'h2, gM - 7'h1, gM - 7'h1));
        repeat (400) @(posedge mclk);
        rd(OFS_STAT, GM, st(4'h2, gM - 7'h1, gM - 7'h1));
        level.nearLimit <= 2'b00;
        repeat (1200) @(posedge mclk);
        rd(OFS_STAT, GM, st(4'h2, gM, gM));
        $display("test level control done");
        i_iga_host_model.wr(OFS_CTRL, 32'h00018007);
        rd(OFS_STAT, 32'h00f00000, 32'h00800000);
        repeat (300) @(posedge mclk);
        i_iga_host_model.wr(OFS_CTRL, 32'h00018001);
        rd(OFS_STAT, 32'h00f00000, 32'h00200000);
        i_iga_host_model.wr(OFS_CTRL, 32'h00018005);
        repeat (6800) @(posedge mclk);
        rd(OFS_STAT, GM, st(4'h8, GAIN_MUTE, GAIN_MUTE));
        i_iga_host_model.wr(OFS_CTRL, 32'h00000000);
        rd(OFS_STAT, GM, st(4'h1, GAIN_MUTE, GAIN_MUTE));
        $display("test fade-out done");
        i_iga_host_model.wr(OFS_GAIN, {25'h0, GAIN_MUTE});
        i_iga_host_model.wr(OFS_CTRL, 32'h00000003);
        rd(OFS_STAT, 32'h00f00000, 32'h00400000);
        repeat (int'(gM) * 256 + 600) @(posedge mclk);
        rd(OFS_STAT, GM, st(4'h2, gM, gM));
        $display("test fade-in done");
        repeat (3) @(posedge mclk);
        final_report();
    end
endmodule : iga_input_gain_ctrl_test

// File: iga_pkg.sv
// shared constants and types for the input gain level and fade controller
package iga_pkg;
    // gain word
    localparam int GAIN_W = 7;
    localparam logic [6:0] GAIN_MUTE = 7'h00;  // mute code
    localparam logic [6:0] GAIN_RST = 7'h00;   // gain after reset
    localparam logic [6:0] REF_RST = 7'h40;    // reference gain after reset
    localparam logic [6:0] FADE_SPAN = 7'h60;  // 96 fade steps, mute to top
    // register offsets
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_GAIN = 4'h4;
    localparam logic [3:0] OFS_REF = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hc;
    // status field positions
    localparam int STAT_GAINL_LSB = 0;
    localparam int STAT_GAINR_LSB = 8;
    localparam int STAT_PEND_LSB = 16;
    localparam int STAT_STATE_LSB = 20;
    // counters, in sample periods
    localparam int CNT_W = 11;
    localparam logic [10:0] ZC_TMO_TBL [4] = '{11'h080, 11'h100, 11'h200, 11'h400};
    localparam logic [10:0] LIM_TMO_TBL [4] = '{11'h008, 11'h010, 11'h020, 11'h040};
    localparam logic [10:0] WAIT_TBL [4] = '{11'h080, 11'h100, 11'h200, 11'h400};
    localparam logic [10:0] FADE_PER_TBL [4] = '{11'h080, 11'h100, 11'h200, 11'h400};
    // control word, bit 0 is level control enable
    localparam int CTRL_W = 17;
    typedef struct packed {
        logic [1:0] fadeStepCount;
        logic [1:0] fadePeriodSelect;
        logic recoveryAttenSelect;
        logic [1:0] limiterAttenStep;
        logic [1:0] zeroCrossTimeoutSelect;
        logic [1:0] recoveryWaitSelect;
        logic [1:0] limiterTimeoutSelect;
        logic limiterZeroCrossDisable;
        logic fadeOutEnable;
        logic fadeInEnable;
        logic inputLevelControlEnable;
    } iga_ctrl_t;
    localparam logic [16:0] CTRL_RST = 17'h00000;
    // level detector flags per channel, bit 0 left, bit 1 right
    typedef struct packed {
        logic [1:0] overLimit;  // above limiter threshold
        logic [1:0] nearLimit;  // above recovery-wait reset level
        logic [1:0] zeroCross;  // one-cycle zero crossing pulse
    } iga_level_t;
    // controller modes
    typedef enum logic [3:0] {
        ST_MAN = 4'b0001,
        ST_ALC = 4'b0010,
        ST_FIN = 4'b0100,
        ST_FOUT = 4'b1000
    } iga_state_t;
endpackage : iga_pkg
